// *** emb_bus.sv ***
`timescale 1ns/10ps
// Contract
// - 8-bit cycles: upper lines carry address only
// - 16-bit cycles: upper lines address then data
// - Lower lines always multiplex address and data
// - Read strobe low only during external reads
// - Latch strobe pulses at external cycle start
// - Config bit 3 high selects latch strobe
// - Config bit 3 low selects address valid
// - Address valid low during data, high after
module emb_bus (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] chip_config_reg_i,
  input wire logic width_select_in_i,
  input wire logic req_i,
  input wire logic req_rd_i,
  input wire logic req_ext_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic [15:0] muxed_addr_data_lines_i,
  output logic [15:0] muxed_addr_data_lines_o,
  output logic [15:0] muxed_addr_data_lines_oe_o,
  output logic rd_n_o,
  output logic strobe_o,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic wide_o
);
  // ----------------------------------------
  // Cycle state and captured request
  // ----------------------------------------
  emb_pkg::emb_state_t state;
  logic [1:0] cnt;
  logic wide;
  logic rd;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic latch_mode;
  logic upper_mux;
  logic load;
  logic take;
  logic wide_req;
  logic data_phase;
  logic data_last;

  // ----------------------------------------
  // Phase decodes
  // ----------------------------------------
  assign latch_mode = chip_config_reg_i[emb_pkg::EMB_CFG_STROBE_SEL_BIT];
  assign upper_mux = wide;
  assign take = (state == emb_pkg::EMB_IDLE) && req_i && req_ext_i;
  assign wide_req = chip_config_reg_i[emb_pkg::EMB_CFG_WIDTH_EN_BIT] & width_select_in_i;
  assign data_phase = (state == emb_pkg::EMB_HOLD) || (state == emb_pkg::EMB_DATA);
  assign data_last = (state == emb_pkg::EMB_DATA) && (cnt == 2'h0);
  assign load = (state == emb_pkg::EMB_DONE) && rd;

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= emb_pkg::EMB_IDLE;
    end else begin
      case (state)
        emb_pkg::EMB_IDLE: begin
          if (take) begin
            state <= emb_pkg::EMB_ADDR;
          end
        end
        emb_pkg::EMB_ADDR: begin
          state <= emb_pkg::EMB_HOLD;
        end
        emb_pkg::EMB_HOLD: begin
          state <= emb_pkg::EMB_DATA;
        end
        emb_pkg::EMB_DATA: begin
          if (data_last) begin
            state <= emb_pkg::EMB_DONE;
          end
        end
        emb_pkg::EMB_DONE: begin
          state <= emb_pkg::EMB_IDLE;
        end
        default: begin
          state <= emb_pkg::EMB_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Data phase counter
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 2'h0;
    end else if (state == emb_pkg::EMB_HOLD) begin
      cnt <= emb_pkg::EMB_DATA_CYCLES - 2'h1;
    end else if ((state == emb_pkg::EMB_DATA) && (cnt != 2'h0)) begin
      cnt <= cnt - 2'h1;
    end
  end

  // ----------------------------------------
  // Cycle kind
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd <= 1'b0;
      wide <= 1'b0;
    end else if (take) begin
      rd <= req_rd_i;
      wide <= wide_req;
    end
  end

  // ----------------------------------------
  // Address and write data
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr <= emb_pkg::EMB_AD_RESET;
      wdata <= emb_pkg::EMB_AD_RESET;
    end else if (take) begin
      addr <= req_addr_i;
      wdata <= req_wdata_i;
    end
  end

  // ----------------------------------------
  // Read strobe
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_n_o <= 1'b1;
    end else begin
      rd_n_o <= !(rd && data_phase);
    end
  end

  // ----------------------------------------
  // Shared strobe pin
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_o <= 1'b0;
    end else if (latch_mode) begin
      strobe_o <= take;
    end else begin
      strobe_o <= !data_phase;
    end
  end

  // ----------------------------------------
  // Busy
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= take || ((state != emb_pkg::EMB_IDLE) && (state != emb_pkg::EMB_DONE));
    end
  end

  // ----------------------------------------
  // Done pulse
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (state == emb_pkg::EMB_DONE);
    end
  end

  // ----------------------------------------
  // Cycle width
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wide_o <= 1'b0;
    end else begin
      wide_o <= wide;
    end
  end

  // ----------------------------------------
  // Byte lanes
  // ----------------------------------------
  emb_lane u_low (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .addr_phase_i(state == emb_pkg::EMB_ADDR),
    .data_phase_i(state == emb_pkg::EMB_HOLD || state == emb_pkg::EMB_DATA),
    .mux_en_i(1'b1),
    .rd_i(rd),
    .load_i(load),
    .addr_i(addr[7:0]),
    .wdata_i(wdata[7:0]),
    .pin_i(muxed_addr_data_lines_i[7:0]),
    .out_o(muxed_addr_data_lines_o[7:0]),
    .oe_o(muxed_addr_data_lines_oe_o[7:0]),
    .rdata_o(rdata_o[7:0])
  );

  emb_lane u_high (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .addr_phase_i(state == emb_pkg::EMB_ADDR),
    .data_phase_i(state == emb_pkg::EMB_HOLD || state == emb_pkg::EMB_DATA),
    .mux_en_i(upper_mux),
    .rd_i(rd),
    .load_i(load && wide),
    .addr_i(addr[15:8]),
    .wdata_i(wdata[15:8]),
    .pin_i(muxed_addr_data_lines_i[15:8]),
    .out_o(muxed_addr_data_lines_o[15:8]),
    .oe_o(muxed_addr_data_lines_oe_o[15:8]),
    .rdata_o(rdata_o[15:8])
  );
endmodule : emb_bus

// *** emb_bus_props.sv ***
`timescale 1ns/10ps
module emb_bus_chk (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] chip_config_reg_i,
  input wire logic width_select_in_i,
  input wire logic req_i,
  input wire logic req_rd_i,
  input wire logic req_ext_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic [15:0] muxed_addr_data_lines_o,
  input wire logic [15:0] muxed_addr_data_lines_oe_o,
  input wire logic rd_n_o,
  input wire logic strobe_o,
  input wire logic busy_o
);
  wire logic tk = req_i && req_ext_i && !busy_o;
  wire logic [15:0] ad = muxed_addr_data_lines_o;
  wire logic [15:0] oe = muxed_addr_data_lines_oe_o;
  wire logic alm = chip_config_reg_i[emb_pkg::EMB_CFG_STROBE_SEL_BIT];
  wire logic wd = chip_config_reg_i[emb_pkg::EMB_CFG_WIDTH_EN_BIT] && width_select_in_i;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_rd_read: assert property (tk && req_rd_i |-> ##3 !rd_n_o [*3] ##1 rd_n_o) else $error("rd");
  a_rd_write: assert property (tk && !req_rd_i |-> ##1 rd_n_o [*6]) else $error("rd write");
  a_latch_pulse: assert property (tk && alm |-> ##1 strobe_o ##1 !strobe_o [*5]) else $error("ale");
  a_valid_low: assert property (tk && !alm |-> ##1 strobe_o [*2] ##1 !strobe_o [*3] ##1 strobe_o)
    else $error("addr valid");
  a_addr_phase: assert property (tk |-> ##2 oe == 16'hFFFF && ad == $past(req_addr_i, 2))
    else $error("addr");
  a_read_release: assert property (tk && req_rd_i |-> ##3
    (oe[7:0] == 8'h00 && (!wd || oe[15:8] == 8'h00)) [*3]) else $error("release");
  a_narrow_upper: assert property (tk && !wd |-> ##3 (oe[15:8] == 8'hFF && $stable(ad[15:8])) [*3])
    else $error("upper");
  a_wide_write: assert property (tk && !req_rd_i && wd |-> ##3 oe == 16'hFFFF && ad == $past(req_wdata_i, 3))
    else $error("wdata");
endmodule : emb_bus_chk
bind emb_bus emb_bus_chk emb_bus_chk_inst (.*);

// *** emb_bus_tb.sv ***
`timescale 1ns/10ps
module emb_bus_tb;
  logic clk_i, rst_b_i, width_select_in_i, req_i, req_rd_i, req_ext_i;
  logic rd_n_o, strobe_o, busy_o, done_o, wide_o;
  logic [7:0] chip_config_reg_i;
  logic [15:0] req_addr_i, req_wdata_i, muxed_addr_data_lines_o, muxed_addr_data_lines_oe_o;
  logic [15:0] muxed_addr_data_lines_i, rdata_o, mem_d, a, m;
  int error_cnt = 0, samples_checked = 0, n;
  assign muxed_addr_data_lines_i = muxed_addr_data_lines_oe_o & muxed_addr_data_lines_o
    | ~muxed_addr_data_lines_oe_o & (!rd_n_o ? mem_d : ~muxed_addr_data_lines_o);
  emb_bus emb_bus_inst (.*);
  emb_mem emb_mem_inst (.clk_i(clk_i), .pins_i(muxed_addr_data_lines_i), .strobe_i(strobe_o),
    .ale_mode_i(chip_config_reg_i[3]), .data_o(mem_d));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  task automatic close_out;
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic t_cycle(input logic [3:0] k);
    for (n = 0; n < 9 && busy_o !== 1'b0; n++) begin
      @(posedge clk_i);
      #2;
    end
    a = 16'hA5C3 ^ {12'h000, k};
    m = {{8{k[2] & k[3]}}, 8'hFF};
    chip_config_reg_i = {4'h0, k[0], 1'b0, k[3], 1'b0};
    {req_rd_i, req_ext_i, width_select_in_i} = {k[1], 1'b1, k[2]};
    {req_addr_i, req_wdata_i, req_i} = {a, ~a, 1'b1};
    @(posedge clk_i);
    #2 req_i = 1'b0;
    for (n = 0; n < 9 && done_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #2;
    end
    if (done_o !== 1'b1) begin
      chk("done", 16'h0001, {15'h0000, done_o});
      close_out();
    end else begin
      chk("wide", m, {{8{wide_o}}, 8'hFF});
      if (k[1]) chk("rdata", ~a & m, rdata_o & m);
      $display("Cycle %0d ended", k);
    end
  endtask : t_cycle
  initial begin
    {rst_b_i, req_i, req_rd_i, req_ext_i, width_select_in_i} = 5'h00;
    {chip_config_reg_i, req_addr_i, req_wdata_i} = 40'h08_0000_0000;
    repeat (12) @(posedge clk_i);
    #2 rst_b_i = 1'b1;
    for (int i = 0; i < 16; i++) t_cycle(i[3:0]);
    {req_ext_i, req_i} = 2'h1;
    repeat (6) @(posedge clk_i);
    #2 chk("idle", 16'h0001, {13'h0000, busy_o, strobe_o, rd_n_o});
    $display("Internal access ended");
    close_out();
  end
endmodule : emb_bus_tb

// *** emb_lane.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// One byte lane of the shared lines
// ----------------------------------------
module emb_lane (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic addr_phase_i,
  input wire logic data_phase_i,
  input wire logic mux_en_i,
  input wire logic rd_i,
  input wire logic load_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] out_o,
  output logic [7:0] oe_o,
  output logic [7:0] rdata_o
);
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_o <= 8'h00;
      oe_o <= 8'h00;
    end else if (!mux_en_i) begin
      out_o <= addr_i;
      oe_o <= 8'hFF;
    end else if (addr_phase_i) begin
      out_o <= addr_i;
      oe_o <= 8'hFF;
    end else if (data_phase_i && rd_i) begin
      out_o <= 8'h00;
      oe_o <= 8'h00;
    end else if (data_phase_i) begin
      out_o <= wdata_i;
      oe_o <= 8'hFF;
    end else begin
      out_o <= 8'h00;
      oe_o <= 8'h00;
    end
  end

  // ----------------------------------------
  // Read capture
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (load_i) begin
      rdata_o <= pin_i;
    end
  end
endmodule : emb_lane

// *** emb_mem_model.sv ***
`timescale 1ns/10ps
module emb_mem (
  input wire logic clk_i,
  input wire logic [15:0] pins_i,
  input wire logic strobe_i,
  input wire logic ale_mode_i,
  output logic [15:0] data_o
);
  logic [15:0] lat;
  logic prev;
  always_ff @(posedge clk_i) begin
    prev <= strobe_i;
    if (ale_mode_i ? (prev && !strobe_i) : strobe_i) begin
      lat <= pins_i;
    end
  end
  assign data_o = ~lat;
endmodule : emb_mem

// *** emb_pkg.sv ***
package emb_pkg;
  // ----------------------------------------
  // Bus cycle phases
  // ----------------------------------------
  typedef enum logic [2:0] {
    EMB_IDLE,
    EMB_ADDR,
    EMB_HOLD,
    EMB_DATA,
    EMB_DONE
  } emb_state_t;

  // ----------------------------------------
  // Widths, field positions, counts, reset values
  // ----------------------------------------
  localparam int unsigned EMB_AW = 16;
  localparam int unsigned EMB_LANE = 8;
  localparam int unsigned EMB_CFG_W = 8;
  localparam int unsigned EMB_CFG_WIDTH_EN_BIT = 1;
  localparam int unsigned EMB_CFG_STROBE_SEL_BIT = 3;
  localparam logic [7:0] EMB_CFG_RESET = 8'h08;
  localparam logic [1:0] EMB_DATA_CYCLES = 2'h2;
  localparam logic [15:0] EMB_AD_RESET = 16'h0000;
endpackage : emb_pkg
